// ---- logic/lsfs_pkg.sv ----
// Constants, types and register map of the LED string fault supervisor
package lsfs_pkg;
    localparam int NCH = 8;
    // Clock and timing
    localparam int CLK_NS = 50;
    localparam int SOFT_TOTAL_NS = 1000000;
    localparam int SOFT_STEPS = 7;
    localparam int SOFT_STEP_CYC = SOFT_TOTAL_NS / (CLK_NS * SOFT_STEPS);
    localparam int OPEN_TO_NS = 6000000;
    localparam int OPEN_TO_CYC = OPEN_TO_NS / CLK_NS;
    localparam int OPEN_HOT_NS = 800000;
    localparam int OPEN_HOT_CYC = OPEN_HOT_NS / CLK_NS;
    // Current limit ladder, 375 mA per level
    localparam int ILIM_STEP_MA = 375;
    localparam logic [2:0] ILIM_MIN = 3'h0;
    localparam logic [2:0] ILIM_MAX = 3'h7;
    // Boost cycle shape in clocks
    localparam logic [7:0] BOOST_PERIOD = 8'h10;
    localparam logic [7:0] BOOST_MAX_ON = 8'h0a;
    localparam logic [7:0] SWNODE_SETTLE = 8'h05;
    // Register indices; byte address is four times the index
    localparam logic [7:0] REG_FAULT_IDX = 8'h02;
    localparam logic [7:0] REG_CFG_IDX = 8'h08;
    localparam logic [7:0] REG_MASK_IDX = 8'h09;
    localparam logic [7:0] REG_IRQEN_IDX = 8'h0a;
    localparam logic [7:0] REG_CTRL_IDX = 8'h0b;
    localparam logic [7:0] REG_STATE_IDX = 8'h0c;
    localparam int AW = 12;
    // Field positions
    localparam int CFG_SC_LOW_BIT = 0;
    localparam int CFG_SC_DIS_BIT = 1;
    localparam int CFG_FREQ_BIT = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int FLT_SHORT = 0;
    localparam int FLT_OPEN = 1;
    localparam int FLT_INOC = 2;
    localparam int FLT_SWNODE = 3;
    localparam int FLT_OVS = 4;
    localparam int FLT_W = 5;
    localparam int CTRL_RESTART_BIT = 0;
    localparam int STAT_ILIM_LSB = 0;
    localparam int STAT_ST_LSB = 4;
    localparam int STAT_GOOD_LSB = 8;
    // Comparator inputs from the analog side
    typedef struct packed {
        logic vin_ok;
        logic fet_hard;
        logic sw_cur_over;
        logic swnode_hi;
        logic ovs_above20;
        logic ovs_hit;
        logic otp_low;
        logic in_overcur;
        logic fb_stable;
        logic [NCH-1:0] short_hi;
        logic [NCH-1:0] short_lo;
        logic [NCH-1:0] cur75;
        logic [NCH-1:0] cur50;
    } lsfs_cmp_t;
    typedef enum logic [2:0] {ST_OFF, ST_PROBE, ST_INRUSH, ST_SOFT, ST_RUN, ST_SHUT} lsfs_st_t;
endpackage

// ---- logic/lsfs_top.sv ----
// LED string start-up and fault supervisor with APB register access
// Functional notes
// - Boost switching starts only after the protection FET reads fully on.
// - A boost pulse ends in any cycle where switch current exceeds the limit.
// - Soft-start limit starts lowest, seven equal steps to full within 1 ms.
// - Every LED fault is recorded in the fault/status register, index 0x02.
// - Mask register 0x09 shows failed channels; host writes disable channels.
// - Short and under-50-percent open faults count only while LED feedback reports stable operation.
// - Input overcurrent shuts all channels; cause latched, registers readable.
// - Channel above selected short threshold is disabled; 0x08 bit 0 selects.
// - Configuration bit 1 disables short detection entirely.
// - Channel at 75 percent is good; good channel under 50 percent is open.
// - Overvoltage or lower over-temperature marks all not-good channels open.
// - Open channel is disabled after a time-out, shorter when hot.
// - Open time-out is 6 ms, or 800 us above lower over-temperature.
// - High forward voltage string stays enabled unless overvoltage or lower over-temperature is reached.
// - Input below lockout stops switching and resets; restart when back.
// - Start-up injects test current; waits for switch node above threshold.
// - Switch node low while power FET is off turns protection FET off.
// - Overvoltage sense rising above 20 percent then falling trips protection.
//
// Added by the designer: the register addresses and the APB interface to the registers.
module lsfs_top
    import lsfs_pkg::*;
#(
    parameter int OPEN_TO = OPEN_TO_CYC,
    parameter int OPEN_HOT = OPEN_HOT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator inputs
    input wire lsfs_cmp_t cmp_in,
    // Power stage and channel controls
    output logic boost_gate,
    output logic [2:0] ilim_level,
    output logic test_current_en,
    output logic prot_fet_on,
    output logic [NCH-1:0] ch_en,
    // Interrupt
    output logic irq
);
    localparam int CW = $bits(lsfs_cmp_t);
    localparam int TW = $clog2(OPEN_TO + 1);

    logic [CW-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
    lsfs_cmp_t c;
    lsfs_st_t st_reg, st_next;
    logic [7:0] cfg_reg, mask_reg, irqen_reg;
    logic [FLT_W-1:0] fault_reg, fset;
    logic [2:0] ilim_reg;
    logic [15:0] step_cnt;
    logic [7:0] cyc_cnt, off_cnt, period;
    logic gate_reg, term_reg, ovs_armed, running, sw_en;
    logic trip_inoc, trip_sw, trip_ovs, trip;
    logic wr_acc, rd_acc, restart;
    logic [31:0] rd_data;
    logic rd_hit;
    logic [NCH-1:0] good_reg, fail_open, fail_short, fail_any;
    logic [7:0] ch_wr;

    // Three-stage sync, a bit changes once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            filt_reg <= '0;
        end else begin
            s1_reg <= cmp_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
        end
    end
    assign c = lsfs_cmp_t'(filt_reg);

    assign running = (st_reg == ST_SOFT) || (st_reg == ST_RUN);
    assign sw_en = running;
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && penable && !pready;
    assign restart = wr_acc && (paddr == AW'({REG_CTRL_IDX, 2'b00}))
        && pwdata[CTRL_RESTART_BIT];

    // Protection trips
    // input overcurrent
    assign trip_inoc = c.in_overcur && (running || st_reg == ST_INRUSH);
    assign trip_sw = sw_en && !gate_reg && (off_cnt == SWNODE_SETTLE) && !c.swnode_hi;
    assign trip_ovs = ovs_armed && !c.ovs_above20;
    assign trip = trip_inoc || trip_sw || trip_ovs;

    // Start-up sequence
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            ST_OFF: begin
                if (c.vin_ok) begin
                    st_next = ST_PROBE;
                end
            end
            ST_PROBE: begin
                if (c.swnode_hi) begin
                    st_next = ST_INRUSH;
                end
            end
            ST_INRUSH: begin
                if (trip) begin
                    st_next = ST_SHUT;
                end else if (c.fet_hard) begin
                    st_next = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (trip) begin
                    st_next = ST_SHUT;
                end else if (ilim_reg == ILIM_MAX) begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (trip) begin
                    st_next = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (restart) begin
                    st_next = ST_OFF;
                end
            end
            default: st_next = ST_OFF;
        endcase
        if (!c.vin_ok) begin
            st_next = ST_OFF;
        end
    end

    // State and stage outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_OFF;
            test_current_en <= 1'b0;
            prot_fet_on <= 1'b0;
        end else begin
            st_reg <= st_next;
            test_current_en <= (st_next == ST_PROBE);
            prot_fet_on <= (st_next == ST_INRUSH) || (st_next == ST_SOFT)
                || (st_next == ST_RUN);
        end
    end

    // Sense excursion arming
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovs_armed <= 1'b0;
        end else if (!running) begin
            ovs_armed <= 1'b0;
        end else if (c.ovs_above20) begin
            ovs_armed <= 1'b1;
        end
    end

    // Soft-start ladder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilim_reg <= ILIM_MIN;
            step_cnt <= '0;
        end else if (!running) begin
            ilim_reg <= ILIM_MIN;
            step_cnt <= '0;
        end else if (ilim_reg != ILIM_MAX) begin
            if (step_cnt == 16'(SOFT_STEP_CYC - 1)) begin
                step_cnt <= '0;
                ilim_reg <= ilim_reg + 3'h1;
            end else begin
                step_cnt <= step_cnt + 16'h1;
            end
        end
    end
    assign ilim_level = ilim_reg;

    // Boost cycle timing
    assign period = cfg_reg[CFG_FREQ_BIT] ? {BOOST_PERIOD[6:0], 1'b0} : BOOST_PERIOD;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt <= '0;
            off_cnt <= '0;
        end else begin
            if (!sw_en || cyc_cnt == period - 8'h1) begin
                cyc_cnt <= '0;
            end else begin
                cyc_cnt <= cyc_cnt + 8'h1;
            end
            if (gate_reg) begin
                off_cnt <= '0;
            end else if (off_cnt != 8'hff) begin
                off_cnt <= off_cnt + 8'h1;
            end
        end
    end

    // Gate with cycle-by-cycle limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_reg <= 1'b0;
            term_reg <= 1'b0;
        end else begin
            if (cyc_cnt == 8'h0) begin
                term_reg <= 1'b0;
            end else if (gate_reg && c.sw_cur_over) begin
                term_reg <= 1'b1;
            end
            // gate needs FET on; lockout or trip ends switching at once
            gate_reg <= sw_en && (st_next == ST_SOFT || st_next == ST_RUN)
                && (cyc_cnt < BOOST_MAX_ON) && !term_reg && !(gate_reg && c.sw_cur_over);
        end
    end
    assign boost_gate = gate_reg;

    // Per-channel good, open and short classification
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        logic pend_reg;
        logic [TW-1:0] to_cnt;
        logic ch_ok;
        logic [TW-1:0] limit;
        assign ch_ok = running && !mask_reg[i];
        assign limit = c.otp_low ? TW'(OPEN_HOT - 1) : TW'(OPEN_TO - 1);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                good_reg[i] <= 1'b0;
                pend_reg <= 1'b0;
                to_cnt <= '0;
            end else if (!ch_ok) begin
                good_reg[i] <= 1'b0;
                pend_reg <= 1'b0;
                to_cnt <= '0;
            end else begin
                if (c.cur75[i]) begin
                    good_reg[i] <= 1'b1;
                end
                // not-good open on overvoltage or heat
                if ((c.ovs_hit || c.otp_low) && !good_reg[i]) begin
                    pend_reg <= 1'b1;
                end else if (good_reg[i] && !c.cur50[i] && c.fb_stable) begin
                    pend_reg <= 1'b1;
                end else if (c.cur75[i]) begin
                    pend_reg <= 1'b0;
                end
                to_cnt <= pend_reg ? to_cnt + TW'(1) : '0;
            end
        end
        assign fail_open[i] = ch_ok && pend_reg && (to_cnt >= limit);
        assign fail_short[i] = ch_ok && c.fb_stable && !cfg_reg[CFG_SC_DIS_BIT]
            && (cfg_reg[CFG_SC_LOW_BIT] ? c.short_lo[i] : c.short_hi[i]);
    end
    assign fail_any = fail_open | fail_short;

    // Fault causes
    // record every fault
    assign fset = {trip_ovs, trip_sw, trip_inoc, |fail_open, |fail_short};

    // Register writes
    assign ch_wr = pwdata[7:0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= CFG_RESET;
            irqen_reg <= '0;
            mask_reg <= MASK_RESET;
            fault_reg <= '0;
        end else begin
            if (wr_acc && paddr == AW'({REG_CFG_IDX, 2'b00})) begin
                cfg_reg <= ch_wr;
            end
            if (wr_acc && paddr == AW'({REG_IRQEN_IDX, 2'b00})) begin
                irqen_reg <= ch_wr;
            end
            // failed channels stick until a host write replaces the mask, host may disable
            if (wr_acc && paddr == AW'({REG_MASK_IDX, 2'b00})) begin
                mask_reg <= ch_wr | fail_any;
            end else begin
                mask_reg <= mask_reg | fail_any;
            end
            if (wr_acc && paddr == AW'({REG_FAULT_IDX, 2'b00})) begin
                fault_reg <= (fault_reg & ~pwdata[FLT_W-1:0]) | fset;
            end else begin
                fault_reg <= fault_reg | fset;
            end
        end
    end

    // Read decode
    always_comb begin
        rd_data = '0;
        rd_hit = 1'b1;
        case (paddr)
            AW'({REG_FAULT_IDX, 2'b00}): rd_data[FLT_W-1:0] = fault_reg;
            AW'({REG_CFG_IDX, 2'b00}): rd_data[7:0] = cfg_reg;
            AW'({REG_MASK_IDX, 2'b00}): rd_data[7:0] = mask_reg;
            AW'({REG_IRQEN_IDX, 2'b00}): rd_data[FLT_W-1:0] = irqen_reg[FLT_W-1:0];
            AW'({REG_CTRL_IDX, 2'b00}): rd_data = '0;
            AW'({REG_STATE_IDX, 2'b00}): begin
                rd_data[STAT_ILIM_LSB +: 3] = ilim_reg;
                rd_data[STAT_ST_LSB +: 3] = st_reg;
                rd_data[STAT_GOOD_LSB +: NCH] = good_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_acc;
            if (rd_acc) begin
                prdata <= pwrite ? '0 : rd_data;
                pslverr <= !rd_hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Channel enables and interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_en <= '0;
            irq <= 1'b0;
        end else begin
            ch_en <= {NCH{running && !trip}} & ~mask_reg & ~fail_any;
            irq <= |(fault_reg & irqen_reg[FLT_W-1:0]);
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_gate_needs_fet: assert property (boost_gate |-> prot_fet_on && !test_current_en)
        else $error("boost switching without protection FET on");
    a_pulse_cut: assert property (gate_reg && c.sw_cur_over |=> !gate_reg ##1 !gate_reg)
        else $error("boost pulse not ended on overcurrent");
    a_ilim_start: assert property ($rose(st_reg == ST_SOFT) |-> ilim_reg == ILIM_MIN)
        else $error("soft-start not at lowest level");
    a_ilim_stepping: assert property ($changed(ilim_reg) && ilim_reg != ILIM_MIN
        |-> ilim_reg == $past(ilim_reg) + 3'h1 && $past(step_cnt) != 16'h0)
        else $error("current limit step wrong");
    a_fault_record: assert property (|fset |=> (fault_reg & $past(fset)) == $past(fset))
        else $error("fault not recorded");
    a_mask_fail: assert property (fail_any[0] |=> mask_reg[0] ##1 !ch_en[0])
        else $error("failed channel not masked");
    a_inoc_shut: assert property (trip_inoc && c.vin_ok |=> st_reg == ST_SHUT ##1
        ch_en == '0 && !prot_fet_on)
        else $error("input overcurrent did not shut down");
    a_short_off: assert property (cfg_reg[CFG_SC_DIS_BIT] |-> fail_short == '0)
        else $error("short detect active while disabled");
    a_vin_stop: assert property (!c.vin_ok |=> st_reg == ST_OFF ##1 !boost_gate)
        else $error("lockout did not stop switching");
    a_probe_hold: assert property (st_reg == ST_PROBE && !c.swnode_hi
        |=> st_reg != ST_INRUSH)
        else $error("start before switch node threshold");
    a_swnode_trip: assert property (trip_sw && c.vin_ok |=> !prot_fet_on)
        else $error("switch node fault did not open FET");

    c_run: cover property (st_reg == ST_SOFT ##1 st_reg == ST_RUN);
    c_open: cover property (|fail_open);
    c_shut: cover property (st_reg == ST_SHUT);
endmodule // lsfs_top

// ---- tb/lsfs_plant.sv ----
// Analog plant model: switch node and protection FET response
module lsfs_plant (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Power stage drive from the supervisor
    input wire logic test_current_en,
    input wire logic prot_fet_on,
    input wire logic boost_gate,
    // Fault injection from the bench
    input wire logic short_gnd,
    // Comparator levels back to the supervisor
    output logic swnode_hi,
    output logic fet_hard
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] chg_reg;
    logic [2:0] fet_reg;
    // output cap charges from test current or the FET
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            chg_reg <= 3'h0;
        else if (!test_current_en && !prot_fet_on)
            chg_reg <= 3'h0;
        else if (chg_reg != 3'h6)
            chg_reg <= chg_reg + 3'h1;
    end
    // node low while switch on or shorted to ground
    assign swnode_hi = (chg_reg >= 3'h4) && !boost_gate && !short_gnd;
    // slow gate charge delays the fully-on level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fet_reg <= 3'h0;
        else
            fet_reg <= {fet_reg[1:0], prot_fet_on};
    end
    assign fet_hard = fet_reg[2];
endmodule // lsfs_plant

// ---- tb/tb_led_string_fault_supervisor.sv ----
// Self-checking bench of the LED string fault supervisor
module tb_led_string_fault_supervisor
    import lsfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int OTO = 40;
    localparam int OHT = 8;
    localparam logic [7:0] RI [3] = '{REG_FAULT_IDX, REG_CFG_IDX, REG_MASK_IDX};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, boost_gate, test_current_en, prot_fet_on, irq;
    logic short_gnd = 1'b0, sw_hi, fet_hard;
    logic [2:0] ilim_level;
    logic [NCH-1:0] ch_en;
    lsfs_cmp_t cmp_drv = '0, cmp_in;
    int n_fail = 0, n_checks = 0, k, n, o, h, s, d, q;

    // Clock
    always #25 pclk = ~pclk;
    // Plant levels merged into the comparator bundle
    always_comb begin
        cmp_in = cmp_drv;
        cmp_in.swnode_hi = sw_hi;
        cmp_in.fet_hard = fet_hard;
    end
    lsfs_top #(.OPEN_TO(OTO), .OPEN_HOT(OHT)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in),
        .boost_gate(boost_gate), .ilim_level(ilim_level), .test_current_en(test_current_en),
        .prot_fet_on(prot_fet_on), .ch_en(ch_en), .irq(irq));
    lsfs_plant i_plant (.pclk(pclk), .presetn(presetn), .test_current_en(test_current_en),
        .prot_fet_on(prot_fet_on), .boost_gate(boost_gate), .short_gnd(short_gnd),
        .swnode_hi(sw_hi), .fet_hard(fet_hard));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // Expected boost period in clocks, doubled at half switching frequency
    function automatic logic [31:0] exp_period(input logic half);
        return half ? 32'(BOOST_PERIOD) << 1 : 32'(BOOST_PERIOD);
    endfunction
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // APB transfer held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] dat);
        int c;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= AW'({i, 2'b00});
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (c = 0; c < 20 && pready !== 1'b1; c++) @(posedge pclk);
        chk(32'(pready), 1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait for the next rising edge of the boost gate
    task automatic rise();
        int c;
        for (c = 0; c < 60 && boost_gate !== 1'b0; c++) @(posedge pclk);
        for (c = 0; c < 300 && boost_gate !== 1'b1; c++) @(posedge pclk);
    endtask
    // Start-up sequence with optional full soft-start ladder
    task automatic start_up(input bit full);
        int c;
        for (c = 0; c < 40 && test_current_en !== 1'b1; c++) @(posedge pclk);
        chk(32'(test_current_en), 1, "no test current");
        chk(32'(prot_fet_on), 0, "fet before probe");
        for (c = 0; c < 60 && prot_fet_on !== 1'b1; c++) @(posedge pclk);
        chk(32'(boost_gate), 0, "switch before fet");
        rise();
        chk(32'(fet_hard), 1, "switch before fet full");
        chk(32'(ilim_level), 32'(ILIM_MIN), "first limit");
        if (full) begin
            for (k = 1; k < 8; k++) begin
                for (c = 0; c < SOFT_STEP_CYC + 40 && ilim_level != 3'(k); c++)
                    @(posedge pclk);
                chk(32'(ilim_level), k, "limit step");
                if (k > 1)
                    chk(32'(c > SOFT_STEP_CYC - 40), 1, "step early");
            end
        end
    endtask

    // Main sequence
    initial begin
        cyc(8);
        presetn <= 1'b1;
        k = $urandom(78);
        o = $urandom_range(7, 0);
        h = (o + 1) % 8;
        s = (o + 2) % 8;
        d = (o + 3) % 8;
        q = (o + 4) % 8;
        cyc(2);
        for (k = 0; k < 3; k++) begin
            apb(1'b0, RI[k], 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        apb(1'b0, 8'h3f, 32'h0);
        chk(32'(err), 1, "unmapped accepted");
        // host disables one channel at start-up
        apb(1'b1, REG_MASK_IDX, 32'(1 << q));
        apb(1'b1, REG_IRQEN_IDX, 32'h1f);
        cmp_drv.cur75 <= ~(8'h1 << h);
        cmp_drv.cur50 <= ~(8'h1 << h);
        cmp_drv.vin_ok <= 1'b1;
        start_up(1'b1);
        chk(32'(ch_en[q]), 0, "masked channel on");
        chk(32'(ch_en[o]), 1, "good channel off");
        chk(32'(ch_en[h]), 1, "weak string dropped");
        // full pulse, then one cut by the current limit
        rise();
        for (n = 0; n < 20 && boost_gate === 1'b1; n++) @(posedge pclk);
        chk(32'(n >= 8), 1, "pulse short");
        rise();
        cmp_drv.sw_cur_over <= 1'b1;
        for (n = 0; n < 20 && boost_gate === 1'b1; n++) @(posedge pclk);
        chk(32'(n >= 3 && n <= 6), 1, "pulse not cut");
        cmp_drv.sw_cur_over <= 1'b0;
        // open string ignored until stable, then timed out
        cmp_drv.cur75[o] <= 1'b0;
        cmp_drv.cur50[o] <= 1'b0;
        cyc(80);
        chk(32'(ch_en[o]), 1, "fault while unstable");
        cmp_drv.fb_stable <= 1'b1;
        cyc(OTO / 2);
        chk(32'(ch_en[o]), 1, "open too soon");
        cyc(OTO);
        chk(32'(ch_en[o]), 0, "open kept on");
        chk(32'(irq), 1, "no interrupt");
        apb(1'b0, REG_FAULT_IDX, 32'h0);
        chk(rd, 32'(1 << FLT_OPEN), "open not logged");
        apb(1'b1, REG_FAULT_IDX, 32'h1f);
        cyc(2);
        chk(32'(irq), 0, "irq after clear");
        apb(1'b1, REG_IRQEN_IDX, 32'h0);
        // hot: not-good channels open with the short time-out
        cmp_drv.otp_low <= 1'b1;
        cyc(OHT + 12);
        chk(32'(ch_en[h]), 0, "hot open kept on");
        chk(32'(ch_en[s]), 1, "good channel dropped");
        chk(32'(irq), 0, "masked irq");
        cmp_drv.otp_low <= 1'b0;
        cmp_drv.short_lo[s] <= 1'b1;
        cyc(10);
        chk(32'(ch_en[s]), 1, "low threshold by default");
        apb(1'b1, REG_CFG_IDX, 32'h1);
        cyc(10);
        chk(32'(ch_en[s]), 0, "short kept on");
        apb(1'b1, REG_CFG_IDX, 32'h7);
        cmp_drv.short_hi[d] <= 1'b1;
        cyc(10);
        chk(32'(ch_en[d]), 1, "short detect not off");
        apb(1'b0, REG_FAULT_IDX, 32'h0);
        chk(rd, 32'h3, "fault record");
        apb(1'b0, REG_MASK_IDX, 32'h0);
        chk(rd, 32'((1 << o) | (1 << h) | (1 << s) | (1 << q)), "failed set");
        // Half switching frequency: one full boost period from rise to rise
        rise();
        for (n = 0; n < 99 && boost_gate === 1'b1; n++) @(posedge pclk);
        for (; n < 99 && boost_gate !== 1'b1; n++) @(posedge pclk);
        chk(n, exp_period(1'b1), "boost period");
        apb(1'b1, REG_CFG_IDX, 32'h3);
        cmp_drv.short_lo <= '0;
        cmp_drv.short_hi <= '0;
        // trips shut the stage and latch the cause
        for (k = 0; k < 3; k++) begin
            apb(1'b1, REG_FAULT_IDX, 32'h1f);
            if (k == 0)
                cmp_drv.in_overcur <= 1'b1;
            if (k == 1)
                short_gnd <= 1'b1;
            if (k == 2) begin
                cmp_drv.ovs_above20 <= 1'b1;
                cyc(10);
                cmp_drv.ovs_above20 <= 1'b0;
            end
            cyc(40);
            chk(32'({prot_fet_on, boost_gate, ch_en}), 0, "not shut");
            apb(1'b0, REG_FAULT_IDX, 32'h0);
            chk(rd, 32'(1 << (FLT_INOC + k)), "trip cause");
            cmp_drv.in_overcur <= 1'b0;
            short_gnd <= 1'b0;
            apb(1'b1, REG_FAULT_IDX, 32'h1f);
            apb(1'b1, REG_CTRL_IDX, 32'h1);
            start_up(1'b0);
        end
        // lockout stops and resets, then restarts
        cmp_drv.vin_ok <= 1'b0;
        cyc(8);
        chk(32'({boost_gate, prot_fet_on, test_current_en}), 0, "runs in lockout");
        apb(1'b0, REG_STATE_IDX, 32'h0);
        chk(32'(rd[6:4]), 32'(ST_OFF), "state after lockout");
        cmp_drv.vin_ok <= 1'b1;
        start_up(1'b0);
        print_verdict();
    end
    // Watchdog
    initial begin
        cyc(60000);
        n_fail++;
        print_verdict();
    end
endmodule // tb_led_string_fault_supervisor
